/* File: include/adc_ctrl_pkg.sv */
// shared constants and types for the adc front-end mode control
package adc_ctrl_pkg;
    // input-select codes
    localparam logic [2:0] SEL_INPUT_A = 3'h0;
    localparam logic [2:0] SEL_INPUT_B = 3'h1;
    localparam logic [2:0] SEL_SHORT = 3'h2;
    localparam logic [2:0] SEL_BOTH = 3'h3;
    localparam logic [2:0] SEL_COMMON = 3'h4;
    localparam logic [2:0] GAIN_MAX_CODE = 3'h6;
    // cycle counts
    localparam int CHOP_DIV = 1024;
    localparam int CHOP_HALF = CHOP_DIV / 2;
    localparam int MOD_DIV_HR = 4;
    localparam int MOD_DIV_LP = 8;
    localparam int QUAL_CYCLES = 3;
    localparam logic [9:0] CHOP_CNT_RST = 10'h000;
    localparam logic [3:0] MOD_CNT_RST = 4'h0;
    localparam logic [15:0] PERIOD_CNT_RST = 16'h0000;
    localparam int WORD_W = 32;
    localparam int RES_W = 31;

    // analog switch closures; names from what each switch ties
    typedef struct packed {
        logic pos_a;      // pos_input_a to amp +
        logic pos_b;      // pos_input_b to amp +
        logic short_res;  // internal 400 ohm short pair
        logic neg_a;      // neg_input_a to amp -
        logic neg_b;      // neg_input_b to amp -
        logic negb_pos;   // neg_input_b to amp +
    } switch_t;

    typedef struct packed {
        logic [2:0] input_select_field;
        logic [2:0] amp_gain_field;
        logic chop_en;
        logic low_power;
        logic [1:0] filt_sel;
        logic sync_cont;
    } cfg_t;

    localparam cfg_t CFG_RST = '{3'h0, 3'h0, 1'b1, 1'b0, 2'h1, 1'b0};

    localparam logic [1:0] FILT_SINC = 2'h0;
    localparam logic [1:0] FILT_FIR = 2'h1;
    localparam logic [1:0] FILT_FIR_HPF = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SYNC = 2'b01,
        ST_STANDBY = 2'b11,
        ST_PDOWN = 2'b10
    } state_t;

    function automatic switch_t decode_sel(input logic [2:0] sel);
        switch_t s;
        s = '0;
        case (sel)
            SEL_INPUT_A:
            begin
                s.pos_a = 1'b1;
                s.neg_a = 1'b1;
            end
            SEL_INPUT_B:
            begin
                s.pos_b = 1'b1;
                s.neg_b = 1'b1;
            end
            SEL_SHORT: s.short_res = 1'b1;
            SEL_BOTH:
            begin
                s.pos_a = 1'b1;
                s.neg_a = 1'b1;
                s.pos_b = 1'b1;
                s.neg_b = 1'b1;
            end
            SEL_COMMON:
            begin
                s.neg_b = 1'b1;
                s.negb_pos = 1'b1;
            end
            default: s = '0;
        endcase
        return s;
    endfunction
endpackage

/* File: core/output_buffer.sv */
// two-entry valid/ready skid buffer for conversion words
`timescale 1ns/1ps
module output_buffer
(
    input wire logic clk_i,                      // master clock
    input wire logic rst_n_i,                    // synchronised reset
    input wire logic in_valid_i,                 // word offered
    output logic in_ready_o,                     // space free
    input wire logic [31:0] in_data_i,           // word in
    output logic out_valid_o,                    // word held
    input wire logic out_ready_i,                // reader takes
    output logic [31:0] out_data_o               // oldest word
);
    logic [31:0] mem_ff [2];
    logic [1:0] cnt_ff;
    logic rd_ff;
    logic wr_ff;
    wire push = in_valid_i && (cnt_ff != 2'h2);
    wire pop = out_ready_i && (cnt_ff != 2'h0);

    assign in_ready_o = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o = mem_ff[rd_ff];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= 2'h0;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
            if (push)
                wr_ff <= ~wr_ff;
            if (pop)
                rd_ff <= ~rd_ff;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data_i;
    end

    a_buf_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cnt_ff <= 2'h2) else $error("buffer count above two");
endmodule

/* File: core/adc_frontend_mode_control.sv */
// mode control for a delta-sigma adc front end
`timescale 1ns/1ps
module adc_frontend_mode_control
(
    input wire logic clk_i,                       // master clock, 10 MHz
    input wire logic rst_n_i,                     // hardware reset, active low
    input wire logic powerdown_pin_n_i,           // power-down pin, active low
    input wire logic sync_i,                      // frame-sync input
    input wire logic cfg_we_i,                    // config write strobe
    input wire adc_ctrl_pkg::cfg_t cfg_i,         // config write data
    input wire logic standby_cmd_i,               // standby command pulse
    input wire logic wakeup_cmd_i,                // wakeup command pulse
    input wire logic overrange_cmp_i,             // full-scale comparator
    input wire logic [30:0] sinc_data_i,          // sinc stage word
    input wire logic [30:0] fir_data_i,           // fir stage word
    input wire logic [30:0] hpf_data_i,           // fir plus hpf word
    input wire logic filt_valid_i,                // filter word strobe
    input wire logic [31:0] scale_gain_i,         // gain scale, 1.0 = 2^30
    input wire logic [31:0] scale_offset_i,       // offset scale
    input wire logic [15:0] frame_period_i,       // conversion period cycles
    output adc_ctrl_pkg::cfg_t cfg_o,             // config readback
    output adc_ctrl_pkg::switch_t switch_o,       // multiplexer switches
    output logic [6:0] amp_gain_o,                // amplifier gain value
    output logic chop_clk_o,                      // chopper drive
    output logic mod_en_o,                        // modulator sample enable
    output logic overload_flag_out_o,             // overload flag
    output logic filt_rst_o,                      // filter/modulator reset
    output logic powered_o,                       // analog powered
    output logic data_valid_o,                    // conversion word ready
    input wire logic data_ready_i,                // serial reader takes word
    output logic [31:0] data_o                    // conversion word
);
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic sync_s1_ff;
    logic sync_s2_ff;
    logic [1:0] sync_q_ff;
    logic sync_qual_ff;
    adc_ctrl_pkg::cfg_t cfg_ff;
    adc_ctrl_pkg::state_t state_ff;
    adc_ctrl_pkg::state_t nxt_state;
    logic [9:0] chop_cnt_ff;
    logic [3:0] mod_cnt_ff;
    logic mod_half_ff;
    logic [15:0] period_cnt_ff;
    logic filt_rst_ff;
    logic mod_en_ff;
    logic chop_ff;
    logic ovl_ff;
    adc_ctrl_pkg::switch_t switch_ff;
    logic [6:0] gain_ff;
    logic buf_in_ready;
    logic buf_valid;
    logic [31:0] buf_data;
    logic data_valid_ff;
    logic [31:0] data_ff;
    logic rst_n;
    logic powered_ff;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_s1_ff <= 1'b0;
            sync_s2_ff <= 1'b0;
            sync_q_ff <= 2'h0;
            sync_qual_ff <= 1'b0;
        end
        else
        begin
            sync_s1_ff <= sync_i;
            sync_s2_ff <= sync_s1_ff;
            sync_q_ff <= {sync_q_ff[0], sync_s2_ff};
            sync_qual_ff <= &{sync_q_ff, sync_s2_ff};
        end
    end
    // glitches shorter than three cycles never reach sync_qual_ff
    wire sync_rise = sync_qual_ff == 1'b0 && (&{sync_q_ff, sync_s2_ff});

    // continuous mode: resync only if edge off the period
    wire period_end = (period_cnt_ff == frame_period_i - 16'h0001);
    wire sync_hit = cfg_ff.sync_cont ? (sync_rise && !period_end) : sync_rise;

    wire pdown = !powerdown_pin_n_i;
    wire active = (state_ff == adc_ctrl_pkg::ST_RUN);
    // taken from the next state so the flopped output moves in step with state_ff
    wire nxt_powered = (nxt_state != adc_ctrl_pkg::ST_PDOWN)
                    && (nxt_state != adc_ctrl_pkg::ST_STANDBY);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            adc_ctrl_pkg::ST_RUN:
            begin
                if (sync_hit)
                    nxt_state = adc_ctrl_pkg::ST_SYNC;
                else if (standby_cmd_i)
                    nxt_state = adc_ctrl_pkg::ST_STANDBY;
            end
            adc_ctrl_pkg::ST_SYNC: nxt_state = adc_ctrl_pkg::ST_RUN;
            adc_ctrl_pkg::ST_STANDBY:
            begin
                if (wakeup_cmd_i)
                    nxt_state = adc_ctrl_pkg::ST_SYNC;
            end
            adc_ctrl_pkg::ST_PDOWN: nxt_state = adc_ctrl_pkg::ST_SYNC;
            default: nxt_state = adc_ctrl_pkg::ST_RUN;
        endcase
        if (pdown)
            nxt_state = adc_ctrl_pkg::ST_PDOWN;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= adc_ctrl_pkg::ST_SYNC;
            powered_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            powered_ff <= nxt_powered;
        end
    end

    // defaults on reset and on power-down
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            cfg_ff <= adc_ctrl_pkg::CFG_RST;
        else if (pdown)
            cfg_ff <= adc_ctrl_pkg::CFG_RST;
        else if (cfg_we_i)
            cfg_ff <= cfg_i;
    end

    // chopper divider, toggles every 512 cycles
    wire chop_wrap = (chop_cnt_ff == 10'(adc_ctrl_pkg::CHOP_HALF - 1));
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chop_cnt_ff <= adc_ctrl_pkg::CHOP_CNT_RST;
            chop_ff <= 1'b0;
        end
        else if (!cfg_ff.chop_en || !active)
        begin
            chop_cnt_ff <= adc_ctrl_pkg::CHOP_CNT_RST;
            chop_ff <= 1'b0;
        end
        else
        begin
            chop_cnt_ff <= chop_wrap ? adc_ctrl_pkg::CHOP_CNT_RST : chop_cnt_ff + 10'h001;
            if (chop_wrap)
                chop_ff <= ~chop_ff;
        end
    end

    // modulator enable at clk/4 or clk/8
    wire [3:0] mod_last = cfg_ff.low_power ? 4'(adc_ctrl_pkg::MOD_DIV_LP - 1)
                                           : 4'(adc_ctrl_pkg::MOD_DIV_HR - 1);
    wire mod_tick = active && (mod_cnt_ff == mod_last);
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mod_cnt_ff <= adc_ctrl_pkg::MOD_CNT_RST;
            mod_half_ff <= 1'b0;
            mod_en_ff <= 1'b0;
        end
        else if (!active)
        begin
            mod_cnt_ff <= adc_ctrl_pkg::MOD_CNT_RST;
            mod_half_ff <= 1'b0;
            mod_en_ff <= 1'b0;
        end
        else
        begin
            mod_cnt_ff <= mod_tick ? adc_ctrl_pkg::MOD_CNT_RST : mod_cnt_ff + 4'h1;
            mod_en_ff <= mod_tick;
            if (mod_tick)
                mod_half_ff <= ~mod_half_ff;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            ovl_ff <= 1'b0;
        else if (!active)
            ovl_ff <= 1'b0;
        else if (mod_tick && mod_half_ff)
            ovl_ff <= overrange_cmp_i;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            period_cnt_ff <= adc_ctrl_pkg::PERIOD_CNT_RST;
        // also cleared by every qualified sync edge, so a locked frame edge lands on period_end
        else if (period_end || sync_rise)
            period_cnt_ff <= adc_ctrl_pkg::PERIOD_CNT_RST;
        else
            period_cnt_ff <= period_cnt_ff + 16'h0001;
    end

    wire adc_ctrl_pkg::switch_t sw_dec = adc_ctrl_pkg::decode_sel(cfg_ff.input_select_field);
    // gain is one shifted by the code, reserved code held at unity
    wire [6:0] gain_dec = (cfg_ff.amp_gain_field > adc_ctrl_pkg::GAIN_MAX_CODE) ? 7'h01
                         : 7'(7'h01 << cfg_ff.amp_gain_field);

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            switch_ff <= '0;
            gain_ff <= 7'h01;
            filt_rst_ff <= 1'b1;
        end
        else
        begin
            switch_ff <= active ? sw_dec : '0;
            gain_ff <= gain_dec;
            // sync state holds filter and modulator in reset
            filt_rst_ff <= !active;
        end
    end

    wire [30:0] stage_sel = (cfg_ff.filt_sel == adc_ctrl_pkg::FILT_SINC) ? sinc_data_i
                          : (cfg_ff.filt_sel == adc_ctrl_pkg::FILT_FIR_HPF) ? hpf_data_i
                          : fir_data_i;
    // scale 31-bit word: gain then offset, saturated
    wire signed [63:0] prod = $signed({{33{stage_sel[30]}}, stage_sel})
                            * $signed({{32{scale_gain_i[31]}}, scale_gain_i});
    wire signed [33:0] shifted = 34'(prod >>> 30);
    wire signed [33:0] summed = shifted - $signed({{2{scale_offset_i[31]}}, scale_offset_i});
    wire signed [31:0] max_w = 32'sh3fffffff;
    wire signed [31:0] min_w = -32'sh40000000;
    wire [31:0] scaled = (summed > 34'(max_w)) ? max_w
                       : (summed < 34'(min_w)) ? min_w : 32'(summed);

    // words held for the serial reader; on stall two are kept, later words dropped
    output_buffer u_buf
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .in_valid_i(filt_valid_i && active),
        .in_ready_o(buf_in_ready),
        .in_data_i(scaled),
        .out_valid_o(buf_valid),
        .out_ready_i(data_ready_i && !data_valid_ff),
        .out_data_o(buf_data)
    );

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_valid_ff <= 1'b0;
            data_ff <= 32'h00000000;
        end
        else if (!data_valid_ff || data_ready_i)
        begin
            data_valid_ff <= buf_valid && data_ready_i && !data_valid_ff;
            if (buf_valid && !data_valid_ff)
                data_ff <= buf_data;
        end
    end

    assign cfg_o = cfg_ff;
    assign switch_o = switch_ff;
    assign amp_gain_o = gain_ff;
    assign chop_clk_o = chop_ff;
    assign mod_en_o = mod_en_ff;
    assign overload_flag_out_o = ovl_ff;
    assign filt_rst_o = filt_rst_ff;
    assign powered_o = powered_ff;
    assign data_valid_o = data_valid_ff;
    assign data_o = data_ff;

    a_mux_input_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        active && cfg_ff.input_select_field == adc_ctrl_pkg::SEL_INPUT_A && $stable(cfg_ff)
        |=> switch_o.pos_a && switch_o.neg_a && !switch_o.pos_b) else $error("pair a not set");
    a_mux_both: assert property (@(posedge clk_i) disable iff (!rst_n)
        active && cfg_ff.input_select_field == adc_ctrl_pkg::SEL_BOTH
        |=> switch_o.pos_a && switch_o.pos_b) else $error("both pairs not closed");
    a_mux_short: assert property (@(posedge clk_i) disable iff (!rst_n)
        active && cfg_ff.input_select_field == adc_ctrl_pkg::SEL_SHORT
        |=> switch_o.short_res && !switch_o.pos_a && !switch_o.neg_b) else $error("short bad");
    a_mux_common: assert property (@(posedge clk_i) disable iff (!rst_n)
        active && cfg_ff.input_select_field == adc_ctrl_pkg::SEL_COMMON
        |=> switch_o.negb_pos && switch_o.neg_b && !switch_o.pos_b) else $error("common bad");
    a_gain_value: assert property (@(posedge clk_i) disable iff (!rst_n)
        cfg_ff.amp_gain_field == 3'h6 |=> amp_gain_o == 7'h40) else $error("gain 64 wrong");
    a_chop_stop: assert property (@(posedge clk_i) disable iff (!rst_n)
        !cfg_ff.chop_en |=> !chop_clk_o) else $error("chopper runs while off");
    a_mod_rate_hr: assert property (@(posedge clk_i) disable iff (!rst_n)
        mod_en_o && !cfg_ff.low_power && active && $stable(cfg_ff) ##1 active
        |-> !mod_en_o ##1 !mod_en_o ##1 !mod_en_o) else $error("mod rate wrong");
    a_pdown_cfg: assert property (@(posedge clk_i) disable iff (!rst_n)
        pdown |=> cfg_o == adc_ctrl_pkg::CFG_RST && !powered_o) else $error("pdown kept cfg");
    a_sync_restart: assert property (@(posedge clk_i) disable iff (!rst_n)
        active && sync_hit && !pdown |=> ##1 filt_rst_o) else $error("sync no restart");
    a_sync_glitch: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(sync_s2_ff) ##1 !sync_s2_ff |-> !sync_rise [*3]) else $error("glitch passed");

    c_standby: cover property (@(posedge clk_i) disable iff (!rst_n)
        state_ff == adc_ctrl_pkg::ST_STANDBY);
    c_overload: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(overload_flag_out_o));
    c_stall: cover property (@(posedge clk_i) disable iff (!rst_n) !buf_in_ready);
    c_sync: cover property (@(posedge clk_i) disable iff (!rst_n) sync_hit);
endmodule

/* File: tb/data_reader.sv */
// behavioural reader that takes conversion words from the block
`timescale 1ns/1ps
module data_reader
(
    input wire logic clk_i,          // master clock
    input wire logic rst_n_i,        // reset, active low
    input wire logic stall_i,        // hold off taking words
    input wire logic data_valid_i,   // word presented
    input wire logic [31:0] data_i,  // word
    output logic data_ready_o        // reader takes words
);
    logic [31:0] got[$];
    // ready moves only after an edge
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            data_ready_o <= 1'b0;
        else
            data_ready_o <= !stall_i;
    end
    // a word counts only when taken
    always @(posedge clk_i)
    begin
        if (data_valid_i === 1'b1 && data_ready_o === 1'b1)
            got.push_back(data_i);
    end
endmodule

/* File: tb/adc_frontend_mode_control_tb.sv */
// self-checking bench for the adc front-end mode control
`timescale 1ns/1ps
module adc_frontend_mode_control_tb;
    logic clk_i, rst_n_i, powerdown_pin_n_i, sync_i, cfg_we_i, standby_cmd_i, wakeup_cmd_i;
    logic overrange_cmp_i, filt_valid_i, data_valid_o, data_ready_i, stall, chop_clk_o;
    logic mod_en_o, overload_flag_out_o, filt_rst_o, powered_o;
    logic [30:0] sinc_data_i, fir_data_i, hpf_data_i, d;
    logic [31:0] scale_offset_i, scale_gain_i, data_o;
    logic [6:0] amp_gain_o;
    adc_ctrl_pkg::cfg_t cfg_i, cfg_o, cfg;
    adc_ctrl_pkg::switch_t switch_o;
    logic [31:0] exp_q[$];
    int seed = 32'h7d58980d;
    int miscompares = 0;
    int num_checks = 0;
    int n, m;
    adc_frontend_mode_control u_adc_frontend_mode_control
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .powerdown_pin_n_i(powerdown_pin_n_i),
        .sync_i(sync_i), .cfg_we_i(cfg_we_i), .cfg_i(cfg_i), .standby_cmd_i(standby_cmd_i),
        .wakeup_cmd_i(wakeup_cmd_i), .overrange_cmp_i(overrange_cmp_i),
        .sinc_data_i(sinc_data_i), .fir_data_i(fir_data_i), .hpf_data_i(hpf_data_i),
        .filt_valid_i(filt_valid_i), .scale_gain_i(scale_gain_i),
        .scale_offset_i(scale_offset_i), .frame_period_i(16'h0100), .cfg_o(cfg_o),
        .switch_o(switch_o), .amp_gain_o(amp_gain_o), .chop_clk_o(chop_clk_o),
        .mod_en_o(mod_en_o), .overload_flag_out_o(overload_flag_out_o),
        .filt_rst_o(filt_rst_o), .powered_o(powered_o), .data_valid_o(data_valid_o),
        .data_ready_i(data_ready_i), .data_o(data_o)
    );
    data_reader u_data_reader
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .data_valid_i(data_valid_o),
        .data_i(data_o), .data_ready_o(data_ready_i)
    );
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    function automatic adc_ctrl_pkg::switch_t exp_sw(input logic [2:0] sel);
        adc_ctrl_pkg::switch_t s;
        s = '0;
        if (sel == 3'h0 || sel == 3'h3) {s.pos_a, s.neg_a} = 2'h3;
        if (sel == 3'h1 || sel == 3'h3) {s.pos_b, s.neg_b} = 2'h3;
        if (sel == 3'h2) s.short_res = 1'b1;
        if (sel == 3'h4) {s.neg_b, s.negb_pos} = 2'h3;
        return s;
    endfunction
    // word times gain (1.0 = 2^30), less the offset, clipped to 31 bits
    function automatic logic [31:0] exp_word(input logic [30:0] w, input logic [31:0] g,
                                             input logic [31:0] off);
        longint v;
        v = (longint'($signed(w)) * longint'($signed(g))) >>> 30;
        v = v - longint'($signed(off));
        if (v > 64'sh3fffffff) v = 64'sh3fffffff;
        if (v < -64'sh40000000) v = -64'sh40000000;
        return v[31:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic span(ref logic s, input logic v);
        n = 0;
        while (s === v && n < 1100)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic watch(input int k);
        repeat (k)
        begin
            @(negedge clk_i);
            if (filt_rst_o !== 1'b0)
                m = 1;
        end
    endtask
    task automatic wr();
        @(negedge clk_i);
        cfg_i = cfg;
        cfg_we_i = 1'b1;
        @(negedge clk_i);
        cfg_we_i = 1'b0;
        cyc(2);
    endtask
    task automatic send(input int fs, input logic [30:0] w, input logic [31:0] off);
        @(negedge clk_i);
        sinc_data_i = (fs == 0) ? w : 31'($random(seed));
        fir_data_i = (fs == 1) ? w : 31'($random(seed));
        hpf_data_i = (fs == 2) ? w : 31'($random(seed));
        scale_offset_i = off;
        filt_valid_i = 1'b1;
        exp_q.push_back(exp_word(w, scale_gain_i, off));
        @(negedge clk_i);
        filt_valid_i = 1'b0;
        cyc(2);
    endtask
    task automatic check_rx();
        chk(32'(u_data_reader.got.size()), 32'(exp_q.size()));
        while (exp_q.size() > 0 && u_data_reader.got.size() > 0)
            chk(u_data_reader.got.pop_front(), exp_q.pop_front());
        exp_q.delete();
        u_data_reader.got.delete();
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #(100 * 20000);
        miscompares++;
        stop_test();
    end
    initial
    begin
        {rst_n_i, sync_i, cfg_we_i, standby_cmd_i, wakeup_cmd_i, overrange_cmp_i} = '0;
        {filt_valid_i, stall, sinc_data_i, fir_data_i, hpf_data_i, scale_offset_i} = '0;
        powerdown_pin_n_i = 1'b1;
        scale_gain_i = 32'h40000000;
        cfg_i = adc_ctrl_pkg::CFG_RST;
        cyc(5);
        rst_n_i = 1'b1;
        cyc(4);
        chk(32'(cfg_o), 32'(adc_ctrl_pkg::CFG_RST));
        chk(32'(amp_gain_o), 32'h1);
        chk(32'(switch_o), 32'(exp_sw(3'h0)));
        for (int i = 0; i < 16; i++)
        begin
            cfg = adc_ctrl_pkg::CFG_RST;
            cfg.input_select_field = i[2:0];
            cfg.amp_gain_field = (i < 8) ? i[2:0] : 3'($random(seed));
            wr();
            chk(32'(cfg_o), 32'(cfg));
            chk(32'(switch_o), 32'(exp_sw(cfg.input_select_field)));
            chk(32'(amp_gain_o), (cfg.amp_gain_field == 3'h7) ? 32'h1 : 32'h1 << cfg.amp_gain_field);
        end
        $display("test mux and gain done");
        cfg = adc_ctrl_pkg::CFG_RST;
        wr();
        span(chop_clk_o, 1'b1);
        span(chop_clk_o, 1'b0);
        span(chop_clk_o, 1'b1);
        chk(32'(n), 32'(adc_ctrl_pkg::CHOP_HALF));
        cfg.chop_en = 1'b0;
        wr();
        span(chop_clk_o, 1'b0);
        chk(32'(n), 32'd1100);
        for (int lp = 0; lp < 2; lp++)
        begin
            cfg.low_power = lp[0];
            wr();
            span(mod_en_o, 1'b0);
            cyc(1);
            span(mod_en_o, 1'b0);
            chk(32'(n + 1), (lp == 1) ? 32'd8 : 32'd4);
        end
        overrange_cmp_i = 1'b1;
        cyc(40);
        chk(32'(overload_flag_out_o), 32'h1);
        overrange_cmp_i = 1'b0;
        cyc(40);
        chk(32'(overload_flag_out_o), 32'h0);
        $display("test chop, rate and overload done");
        m = 0;
        sync_i = 1'b1;
        cyc(1);
        sync_i = 1'b0;
        watch(12);
        chk(32'(m), 32'h0);
        sync_i = 1'b1;
        watch(5);
        sync_i = 1'b0;
        watch(10);
        chk(32'(m), 32'h1);
        cyc(5);
        chk(32'(filt_rst_o), 32'h0);
        // continuous mode: a frame edge exactly one period later must not resync
        cfg.sync_cont = 1'b1;
        wr();
        sync_i = 1'b1;
        cyc(5);
        sync_i = 1'b0;
        cyc(20);
        m = 0;
        watch(231);
        sync_i = 1'b1;
        watch(5);
        sync_i = 1'b0;
        watch(10);
        chk(32'(m), 32'h0);
        sync_i = 1'b1;
        watch(5);
        sync_i = 1'b0;
        watch(10);
        chk(32'(m), 32'h1);
        $display("test sync done");
        for (int fs = 0; fs < 3; fs++)
        begin
            cfg.filt_sel = fs[1:0];
            wr();
            for (int k = 0; k < 4; k++)
            begin
                d = 31'($signed($random(seed)) >>> 7);
                scale_gain_i = (k == 0) ? 32'h40000000 : 32'($random(seed));
                send(fs, d, (k == 3) ? 32'h0 : 32'($random(seed) % 1000));
            end
            cyc(10);
            check_rx();
        end
        scale_gain_i = 32'h40000000;
        stall = 1'b1;
        for (int k = 0; k < 3; k++)
            send(2, 31'($random(seed)), 32'h0);
        void'(exp_q.pop_back());
        chk(32'(u_data_reader.got.size()), 32'h0);
        stall = 1'b0;
        cyc(10);
        check_rx();
        send(2, 31'h3fffffff, 32'hffffffff);
        send(2, 31'h40000000, 32'h00000001);
        cyc(10);
        check_rx();
        $display("test data path done");
        @(negedge clk_i);
        standby_cmd_i = 1'b1;
        @(negedge clk_i);
        standby_cmd_i = 1'b0;
        cyc(1);
        chk(32'(powered_o), 32'h0);
        chk(32'(filt_rst_o), 32'h1);
        wakeup_cmd_i = 1'b1;
        @(negedge clk_i);
        wakeup_cmd_i = 1'b0;
        cyc(5);
        chk(32'(powered_o), 32'h1);
        cfg.input_select_field = 3'h1;
        wr();
        powerdown_pin_n_i = 1'b0;
        cyc(3);
        chk(32'(cfg_o), 32'(adc_ctrl_pkg::CFG_RST));
        chk(32'(powered_o), 32'h0);
        wr();
        chk(32'(cfg_o), 32'(adc_ctrl_pkg::CFG_RST));
        powerdown_pin_n_i = 1'b1;
        cyc(6);
        chk(32'(cfg_o), 32'(adc_ctrl_pkg::CFG_RST));
        chk(32'(powered_o), 32'h1);
        wr();
        rst_n_i = 1'b0;
        cyc(2);
        chk(32'(cfg_o), 32'(adc_ctrl_pkg::CFG_RST));
        chk(32'(amp_gain_o), 32'h1);
        rst_n_i = 1'b1;
        cyc(6);
        chk(32'(powered_o), 32'h1);
        $display("test power and reset done");
        stop_test();
    end
endmodule
